// *** eeprom_write_pkg.sv ***
// Constants shared by the serial EEPROM write path
package eeprom_write_pkg;
  // Array geometry
  localparam int          ADDR_W        = 11;       // 2 Kbyte array
  localparam int          PAGE_W        = 5;        // 32-byte page
  localparam int          PAGE_BYTES    = 32;
  localparam int          BYTE_W        = 8;
  localparam int          ADDR_BYTES    = 2;        // Address bytes after the opcode
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  // Instruction code of the array write command
  localparam logic [7:0]  WRITE_OPCODE  = 8'h02;
  // Array byte values
  localparam logic [7:0]  ERASED_BYTE   = 8'h00;    // Erased bits read as 0
  localparam logic [7:0]  DELIVERY_BYTE = 8'hff;
  // Block-protect encodings
  localparam logic [1:0]  BP_NONE       = 2'h0;
  localparam logic [1:0]  BP_QUARTER    = 2'h1;
  localparam logic [1:0]  BP_HALF       = 2'h2;
  localparam logic [1:0]  BP_ALL        = 2'h3;
  localparam logic [1:0]  BP_DELIVERY   = 2'h0;
  localparam logic        LOCK_DELIVERY = 1'b0;
  // Timing: programming cycle time in microseconds at the clock rate in MHz
  localparam int          CLK_MHZ       = 50;
  localparam int          PROG_TIME_US  = 5000;
  localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  // Buffer in the data path
  localparam int          BUF_DEPTH     = 2;
endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
module pin_sync
  import eeprom_write_pkg::*;
#(
  parameter int        WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // pin_sync

// *** byte_buffer.sv ***
// Small valid/ready buffer for received data bytes
module byte_buffer
  import eeprom_write_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_buffer: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W:0]   wr_ptr_ff;
  logic [PTR_W:0]   rd_ptr_ff;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // Pointers carry one extra bit to tell full from empty
  assign full        = (wr_ptr_ff[PTR_W] != rd_ptr_ff[PTR_W]) &&
                       (wr_ptr_ff[PTR_W-1:0] == rd_ptr_ff[PTR_W-1:0]);
  assign empty       = (wr_ptr_ff == rd_ptr_ff);
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[rd_ptr_ff[PTR_W-1:0]];

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  // Storage needs no reset; empty pointers hide stale words
  always_ff @(posedge clock_i) begin
    if (ce_i && push) begin
      mem_ff[wr_ptr_ff[PTR_W-1:0]] <= in_data_i;
    end
  end
endmodule // byte_buffer

// *** eeprom_page_write.sv ***
// SPI EEPROM array write: command decode, page latch and self-timed programming
//
// Overview of operation
// R1: Host selects, sends opcode, address, data.
// R2: Deselect at byte boundary starts timed programming.
// R3: Further data bytes programmed together in page.
// R4: Only offset bits advance; wrap inside page.
// R5: Write ignored without write permit latch set.
// R6: Write arriving during programming is rejected.
// R7: Deselect off byte boundary discards the write.
// R8: Writes into block-protected region are refused.
// R9: Erase to zero, then program the ones.
// R10: Power-up deselected; falling select needed first.
// R11: Power-up clears permit latch and busy flag.
// R12: Protect and lock bits survive power cycles.
// R13: Delivery state: array FFh, status bits zero.
// R14: Busy flag reads one while programming runs.
// R15: Completion clears the write permit latch.
// R16: Data sampled on clock rise, MSB first.
module eeprom_page_write
  import eeprom_write_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_sdi_i,
  input  wire logic              set_write_permit_i,
  input  wire logic              nv_load_i,
  input  wire logic [1:0]        nv_block_protect_i,
  input  wire logic              nv_status_write_lock_i,
  input  wire logic              factory_init_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [7:0]        rd_data_o,
  output logic                   write_busy_flag_o,
  output logic                   write_permit_latch_o,
  output logic                   block_protect_hi_o,
  output logic                   block_protect_lo_o,
  output logic                   status_write_lock_o,
  output logic                   write_done_o,
  output logic                   write_rejected_o
);
  localparam int CNT_W  = $clog2(PROG_CYCLES_P + 1);
  localparam int HALF_C = PROG_CYCLES_P / 2;

  if (PROG_CYCLES_P < 4) begin : g_bad_prog
    $error("eeprom_page_write: PROG_CYCLES_P must be at least 4");
  end

  typedef enum logic [2:0] {F_IDLE, F_OPCODE, F_ADDR, F_DATA, F_IGNORE} frame_t;
  typedef enum logic [1:0] {P_IDLE, P_DRAIN, P_ERASE, P_PROGRAM} prog_t;

  // Pin synchronisers; select resets low, so a select held low through reset starts nothing
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;

  pin_sync #(.WIDTH(2), .RST_VAL(2'b00)) u_sync_ctl (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .async_i ({spi_cs_n_i, spi_sclk_i}),
    .sync_o  ({cs_n_s, sclk_s})
  );

  pin_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_dat (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .async_i (spi_sdi_i),
    .sync_o  (sdi_s)
  );

  // Edge detection on the synchronised pins
  logic cs_n_d_ff;
  logic sclk_d_ff;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;

  // Delayed select resets low like its synchroniser: no fall until the pin has been high
  assign cs_fall   = cs_n_d_ff && !cs_n_s;                 // R10
  assign cs_rise   = !cs_n_d_ff && cs_n_s;
  assign sclk_rise = !sclk_d_ff && sclk_s && !cs_n_s;      // R16

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cs_n_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else if (ce_i) begin
      cs_n_d_ff <= cs_n_s;
      sclk_d_ff <= sclk_s;
    end
  end

  // Serial shifter and frame tracking
  frame_t           frame_ff;
  frame_t           nxt_frame;
  logic [2:0]       bit_cnt_ff;
  logic [6:0]       shift_ff;
  logic [7:0]       rx_byte;
  logic             byte_done;
  logic             addr_cnt_ff;
  logic [ADDR_W-1:0]      addr_ff;
  logic [PAGE_W-1:0]      off_ff;
  logic             got_data_ff;
  logic             overrun_ff;
  logic             busy_ff;
  logic             permit_ff;
  logic [1:0]       bp_ff;
  logic             lock_ff;
  prog_t            prog_ff;

  assign rx_byte   = {shift_ff, sdi_s};                    // R16
  assign byte_done = sclk_rise && (bit_cnt_ff == BIT_LAST);

  // Frame progression on completed bytes
  always_comb begin
    nxt_frame = frame_ff;
    case (frame_ff)
      F_IDLE:   nxt_frame = frame_ff;
      F_OPCODE: begin
        if (byte_done) begin
          // R1: only the write opcode proceeds; R6: busy device ignores it
          nxt_frame = (rx_byte == WRITE_OPCODE && !busy_ff && prog_ff == P_IDLE) ? F_ADDR : F_IGNORE; // R6
        end
      end
      F_ADDR:   nxt_frame = (byte_done && addr_cnt_ff) ? F_DATA : frame_ff;
      F_DATA:   nxt_frame = frame_ff;
      F_IGNORE: nxt_frame = frame_ff;
      default:  nxt_frame = F_IDLE;
    endcase
    if (cs_fall) begin
      nxt_frame = F_OPCODE;                                // R10
    end else if (cs_rise) begin
      nxt_frame = F_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      frame_ff <= F_IDLE;                                  // R10
    end else if (ce_i) begin
      frame_ff <= nxt_frame;
    end
  end

  // Bit counter restarts at every selection; shift register keeps its bits
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
    end else if (ce_i) begin
      if (cs_fall) begin
        bit_cnt_ff <= '0;
      end else if (sclk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shift_ff   <= rx_byte[6:0];                        // R16
      end
    end
  end

  // Address capture: high byte then low byte; top bits beyond the array ignored
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      addr_cnt_ff <= 1'b0;
      addr_ff     <= '0;
      off_ff      <= '0;
    end else if (ce_i) begin
      if (cs_fall) begin
        addr_cnt_ff <= 1'b0;
      end else if (frame_ff == F_ADDR && byte_done) begin
        addr_cnt_ff <= 1'b1;
        addr_ff     <= {addr_ff[ADDR_W-9:0], rx_byte};
        off_ff      <= rx_byte[PAGE_W-1:0];
      end else if (frame_ff == F_DATA && byte_done) begin
        off_ff      <= off_ff + 1'b1;                      // R4
      end
    end
  end

  // Data bytes travel through the buffer with their page offset
  logic                     push_valid;
  logic                     push_ready;
  logic                     pop_valid;
  logic                     pop_ready;
  logic [PAGE_W+BYTE_W-1:0] pop_data;

  assign push_valid = (frame_ff == F_DATA) && byte_done;
  // Page latch stalls while the array is being erased or programmed
  assign pop_ready  = (prog_ff == P_IDLE) || (prog_ff == P_DRAIN);

  byte_buffer #(.WIDTH(PAGE_W + BYTE_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   ({off_ff, rx_byte}),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // A byte that finds the buffer full spoils the whole write
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      got_data_ff <= 1'b0;
      overrun_ff  <= 1'b0;
    end else if (ce_i) begin
      if (cs_fall) begin
        got_data_ff <= 1'b0;
        overrun_ff  <= 1'b0;
      end else if (push_valid) begin
        got_data_ff <= 1'b1;
        overrun_ff  <= overrun_ff || !push_ready;
      end
    end
  end

  // Page latch: later bytes at a wrapped offset overwrite earlier ones
  logic [7:0]            page_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] loaded_ff;
  logic                  pop_fire;

  assign pop_fire = pop_valid && pop_ready;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      loaded_ff <= '0;
    end else if (ce_i) begin
      if (cs_fall && prog_ff == P_IDLE) begin
        loaded_ff <= '0;
      end else if (pop_fire) begin
        loaded_ff[pop_data[PAGE_W+BYTE_W-1:BYTE_W]] <= 1'b1;  // R3
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (ce_i && pop_fire) begin
      page_ff[pop_data[PAGE_W+BYTE_W-1:BYTE_W]] <= pop_data[BYTE_W-1:0];  // R4
    end
  end

  // Acceptance checks at deselect
  logic protected_page;
  logic commit_ok;
  logic end_of_write;

  // Upper quarter, upper half or the whole array is read-only
  assign protected_page = (bp_ff == BP_ALL) ||
                          (bp_ff == BP_HALF && addr_ff[ADDR_W-1]) ||
                          (bp_ff == BP_QUARTER && (&addr_ff[ADDR_W-1:ADDR_W-2]));  // R8
  assign end_of_write   = cs_rise && (frame_ff == F_DATA);
  assign commit_ok      = (bit_cnt_ff == 3'h0) && got_data_ff   // R7
                          && permit_ff                          // R5
                          && !protected_page                    // R8
                          && !overrun_ff;

  // Self-timed cycle: drain the buffer, erase, then program
  logic [CNT_W-1:0] prog_cnt_ff;
  logic             pend_ok_ff;
  logic             drain_done;

  assign drain_done = (prog_ff == P_DRAIN) && !pop_valid;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prog_ff     <= P_IDLE;
      prog_cnt_ff <= '0;
      pend_ok_ff  <= 1'b0;
    end else if (ce_i) begin
      case (prog_ff)
        P_IDLE: begin
          if (end_of_write) begin
            prog_ff    <= P_DRAIN;                         // R2
            pend_ok_ff <= commit_ok;
          end
        end
        P_DRAIN: begin
          if (drain_done) begin
            prog_ff     <= pend_ok_ff ? P_ERASE : P_IDLE;  // R7
            prog_cnt_ff <= CNT_W'(PROG_CYCLES_P - 1);
          end
        end
        P_ERASE: begin
          prog_cnt_ff <= prog_cnt_ff - 1'b1;
          if (prog_cnt_ff == CNT_W'(HALF_C)) begin
            prog_ff <= P_PROGRAM;                          // R9
          end
        end
        P_PROGRAM: begin
          prog_cnt_ff <= prog_cnt_ff - 1'b1;
          if (prog_cnt_ff == '0) begin
            prog_ff <= P_IDLE;                             // R2
          end
        end
        default: prog_ff <= P_IDLE;
      endcase
    end
  end

  // Busy spans acceptance through the end of the timed cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_ff <= 1'b0;                                     // R11
    end else if (ce_i) begin
      if (prog_ff == P_IDLE && end_of_write && commit_ok) begin
        busy_ff <= 1'b1;                                   // R14
      end else if (prog_ff == P_PROGRAM && prog_cnt_ff == '0) begin
        busy_ff <= 1'b0;                                   // R2
      end
    end
  end

  // Permit latch: set by the enable command, cleared at completion
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      permit_ff <= 1'b0;                                   // R11
    end else if (ce_i) begin
      if (prog_ff == P_PROGRAM && prog_cnt_ff == '0) begin
        permit_ff <= 1'b0;                                 // R15
      end else if (set_write_permit_i) begin
        permit_ff <= 1'b1;
      end
    end
  end

  // Event pulses
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      write_done_o     <= 1'b0;
      write_rejected_o <= 1'b0;
    end else if (ce_i) begin
      write_done_o     <= (prog_ff == P_PROGRAM) && (prog_cnt_ff == '0);
      write_rejected_o <= drain_done && !pend_ok_ff;
    end
  end

  // Non-volatile status bits are untouched by the power-up reset
  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      if (factory_init_i) begin
        bp_ff   <= BP_DELIVERY;                            // R13
        lock_ff <= LOCK_DELIVERY;
      end else if (nv_load_i && !busy_ff) begin
        bp_ff   <= nv_block_protect_i;                     // R12
        lock_ff <= nv_status_write_lock_i;
      end
    end
  end

  // Array storage; it keeps its contents through reset
  logic [7:0]        mem_ff [1 << ADDR_W];
  logic [ADDR_W-1:0] page_base;

  assign page_base = {addr_ff[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};

  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      if (factory_init_i) begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
          mem_ff[i] <= DELIVERY_BYTE;                      // R13
        end
      end else begin
        for (int j = 0; j < PAGE_BYTES; j++) begin
          if (loaded_ff[j] && prog_ff == P_DRAIN && drain_done && pend_ok_ff) begin
            mem_ff[page_base + ADDR_W'(j)] <= ERASED_BYTE; // R9
          end else if (loaded_ff[j] && prog_ff == P_ERASE && prog_cnt_ff == CNT_W'(HALF_C)) begin
            mem_ff[page_base + ADDR_W'(j)] <= mem_ff[page_base + ADDR_W'(j)] | page_ff[j];  // R9
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_data_o <= '0;
    end else if (ce_i) begin
      rd_data_o <= mem_ff[rd_addr_i];
    end
  end

  // Status outputs straight from their flops
  assign write_busy_flag_o    = busy_ff;                   // R14
  assign write_permit_latch_o = permit_ff;
  assign block_protect_hi_o   = bp_ff[1];
  assign block_protect_lo_o   = bp_ff[0];
  assign status_write_lock_o  = lock_ff;
endmodule // eeprom_page_write

// *** eeprom_write_monitor.sv ***
// Checker for the EEPROM write block ports, bound into every instance of the block
module eeprom_write_monitor
  import eeprom_write_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic nv_load_i,
  input wire logic factory_init_i,
  input wire logic write_busy_flag_o,
  input wire logic write_permit_latch_o,
  input wire logic block_protect_hi_o,
  input wire logic block_protect_lo_o,
  input wire logic status_write_lock_o,
  input wire logic write_done_o,
  input wire logic write_rejected_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  bit          nv_seen_ff;  // Two-state on purpose: the stored bits are undefined until first loaded

  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // Enabled cycles of the current busy stretch; a frozen block does not age
  assign nxt_busy_cnt = !ce_i ? busy_cnt_ff : (write_busy_flag_o ? busy_cnt_ff + 32'h1 : 32'h0);
  always_ff @(posedge clock_i) busy_cnt_ff <= srst_i ? 32'h0 : nxt_busy_cnt;
  always_ff @(posedge clock_i) nv_seen_ff <= nv_seen_ff | nv_load_i | factory_init_i;

  a_done_ends_busy: assert property ($fell(write_busy_flag_o) && !$past(srst_i) |-> write_done_o)
    else $error("busy dropped without a done pulse");
  a_done_after_busy: assert property (write_done_o |-> $past(write_busy_flag_o) && !write_busy_flag_o)
    else $error("done pulse not at end of busy");
  a_busy_full_time: assert property (write_done_o |-> busy_cnt_ff >= PROG_CYCLES_P &&
                                     busy_cnt_ff <= PROG_CYCLES_P + 8)
    else $error("programming time out of range");
  a_done_one_cycle: assert property (write_done_o |=> !write_done_o)
    else $error("done pulse longer than one cycle");
  a_reject_one_cycle: assert property (write_rejected_o |=> !write_rejected_o)
    else $error("reject pulse longer than one cycle");
  a_reject_no_busy: assert property (write_rejected_o |-> !write_busy_flag_o [*3])
    else $error("discarded write started programming");
  a_done_drops_permit: assert property (write_done_o |-> !write_permit_latch_o)
    else $error("permit latch kept after completion");
  a_permit_falls_done: assert property ($fell(write_permit_latch_o) && !$past(srst_i) |-> write_done_o)
    else $error("permit latch cleared without completion");
  a_reset_state: assert property ($past(srst_i) |-> !write_busy_flag_o && !write_permit_latch_o &&
                                  !write_done_o && !write_rejected_o)
    else $error("state after reset not cleared");
  a_nv_retained: assert property (nv_seen_ff && !$past(nv_load_i) && !$past(factory_init_i) |->
    $stable({block_protect_hi_o, block_protect_lo_o, status_write_lock_o}))
    else $error("protect or lock bits changed on their own");

  c_write_done: cover property (write_done_o);
  c_write_rejected: cover property (write_rejected_o);
  c_busy_start: cover property ($rose(write_busy_flag_o));
endmodule // eeprom_write_monitor

bind eeprom_page_write eeprom_write_monitor #(.PROG_CYCLES_P(PROG_CYCLES_P)) mon (
  .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .nv_load_i(nv_load_i), .factory_init_i(factory_init_i),
  .write_busy_flag_o(write_busy_flag_o), .write_permit_latch_o(write_permit_latch_o),
  .block_protect_hi_o(block_protect_hi_o), .block_protect_lo_o(block_protect_lo_o),
  .status_write_lock_o(status_write_lock_o), .write_done_o(write_done_o),
  .write_rejected_o(write_rejected_o));

// *** spi_host_model.sv ***
// Host SPI controller model: drives select, serial clock and serial data
module spi_host_model (
  output logic spi_cs_n_o,
  output logic spi_sclk_o,
  output logic spi_sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 80;  // 160 ns serial clock

  // Idle: deselected, clock parked low from power-up on
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_sdi_o  = 1'b0;
  end

  // One frame of nbits bits from the byte queue, MSB first; a short last byte aborts mid-byte
  task automatic frame(input logic [7:0] q[$], input int nbits);
    logic [7:0] b;
    #7;  // Keeps the link edges off the system clock edges
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      b = q[i / 8];
      spi_sdi_o = b[7 - (i % 8)];
      #HALF spi_sclk_o = 1'b1;
      #HALF spi_sclk_o = 1'b0;
    end
    #40 spi_cs_n_o = 1'b1;
    spi_sdi_o = ~spi_sdi_o;  // Data line inverted after deselect: the last bit's value is not left on it
    #200;  // Select stays high well over three clocks between frames
  endtask
endmodule // spi_host_model

// *** tb_top.sv ***
// Self-checking testbench for the EEPROM page write block
module tb_top;
  import eeprom_write_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 400;
  logic              clock_i, srst_i, ce_i, set_permit, nv_load, nv_lock, factory_init;
  logic [1:0]        nv_bp;
  logic [ADDR_W-1:0] rd_addr, base;
  logic [7:0]        rd_data;
  logic              busy, permit, bp_hi, bp_lo, lock, done, rejected, cs_n, sclk, sdi;
  logic [7:0]        mem_exp [2**ADDR_W];
  int                seed = 47, fails = 0, checks_done = 0, done_cnt = 0, rej_cnt = 0, d0;
  int                lens [4] = '{1, 32, 33, 40};

  eeprom_page_write #(.PROG_CYCLES_P(PROG)) dut (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_sdi_i(sdi), .set_write_permit_i(set_permit), .nv_load_i(nv_load), .nv_block_protect_i(nv_bp),
    .nv_status_write_lock_i(nv_lock), .factory_init_i(factory_init), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .write_busy_flag_o(busy), .write_permit_latch_o(permit),
    .block_protect_hi_o(bp_hi), .block_protect_lo_o(bp_lo), .status_write_lock_o(lock),
    .write_done_o(done), .write_rejected_o(rejected));
  spi_host_model host (.spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_sdi_o(sdi));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Pulses are counted here, since they may land while a frame task still runs
  always @(posedge clock_i) begin
    if (done === 1'b1) done_cnt++;
    if (rejected === 1'b1) rej_cnt++;
  end
  // Watchdog
  initial begin
    repeat (95000) @(posedge clock_i);
    check(8'h00, 8'h01);
    stop_test();
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic pulse_permit();
    @(posedge clock_i) set_permit <= 1'b1;
    @(posedge clock_i) set_permit <= 1'b0;
  endtask

  task automatic load_nv(input logic [1:0] bp);
    @(posedge clock_i);
    nv_bp   <= bp;
    nv_lock <= bp[0];
    nv_load <= 1'b1;
    @(posedge clock_i) nv_load <= 1'b0;
    tick(2);
  endtask

  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock_i) rd_addr <= a;
    @(posedge clock_i);
    #1 check(rd_data, e);
  endtask

  task automatic page_chk(input logic [ADDR_W-1:0] a);
    for (int i = 0; i < PAGE_BYTES; i++) read_chk({a[10:5], i[4:0]}, mem_exp[{a[10:5], i[4:0]}]);
  endtask

  // Opcode, two address bytes, n data bytes, then tail bits of a spare byte
  task automatic send(input logic [ADDR_W-1:0] a, input int n, input int tail, input bit upd);
    logic [7:0] q[$];
    logic [7:0] d;
    q = '{WRITE_OPCODE, {5'h0, a[10:8]}, a[7:0], 8'h5a};
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      q.insert(3 + k, d);
      if (upd) mem_exp[{a[10:5], a[4:0] + k[4:0]}] = d;
    end
    host.frame(q, (3 + n) * 8 + tail);
  endtask

  task automatic wait_done(input int c0);
    for (int i = 0; i < PROG + 200 && done_cnt == c0; i++) @(posedge clock_i);
    if (done_cnt == c0) begin
      check(8'h00, 8'h01);
      stop_test();
    end
  endtask

  task automatic accepted(input logic [ADDR_W-1:0] a, input int n);
    pulse_permit();
    d0 = done_cnt;
    send(a, n, 0, 1);
    check({7'h0, busy}, 8'h01);
    read_chk(a, ERASED_BYTE);
    wait_done(d0);
    #1 check({7'h0, permit}, 8'h00);
    page_chk(a);
  endtask

  task automatic refused(input logic [ADDR_W-1:0] a, input int n, input int tail, input bit perm);
    int r0;
    if (perm) pulse_permit();
    r0 = rej_cnt;
    send(a, n, tail, 0);
    tick(20);
    check({7'h0, busy}, 8'h00);
    check(8'(rej_cnt - r0), 8'h01);
    page_chk(a);
  endtask

  initial begin
    srst_i = 1'b1;
    ce_i = 1'b1;
    set_permit = 1'b0;
    nv_load = 1'b0;
    nv_lock = 1'b0;
    nv_bp = 2'h0;
    factory_init = 1'b0;
    rd_addr = '0;
    foreach (mem_exp[i]) mem_exp[i] = DELIVERY_BYTE;
    tick(2);
    srst_i <= 1'b0;
    @(posedge clock_i) factory_init <= 1'b1;
    @(posedge clock_i) factory_init <= 1'b0;
    tick(2);
    check({5'h0, bp_hi, bp_lo, lock}, 8'h00);
    check({6'h0, busy, permit}, 8'h00);
    for (int i = 0; i < 4; i++) read_chk(11'($random(seed)), DELIVERY_BYTE);
    $display("test delivery state finished");
    // Single byte, full page, wrap by one, wrap by eight, then random lengths
    for (int t = 0; t < 8; t++) accepted(11'($random(seed)), t < 4 ? lens[t] : 1 + {$random(seed)} % 40);
    $display("test page writes finished");
    refused(11'h123, 2, 0, 1'b0);
    refused(11'h2c4, 2, 3, 1'b1);
    refused(11'h3a0, 0, 0, 1'b1);
    $display("test discarded frames finished");
    for (int bp = 1; bp < 4; bp++) begin
      load_nv(bp[1:0]);
      base = bp == 3 ? 11'h000 : (bp == 2 ? 11'h400 : 11'h600);
      refused(base, 1, 0, 1'b1);
      if (bp != 3) accepted(base - 11'h020, 2);
    end
    $display("test block protect finished");
    @(posedge clock_i) srst_i <= 1'b1;
    tick(2);
    srst_i <= 1'b0;
    tick(2);
    check({5'h0, bp_hi, bp_lo, lock}, 8'h07);
    check({6'h0, busy, permit}, 8'h00);
    load_nv(2'h0);
    $display("test retention finished");
    pulse_permit();
    d0 = done_cnt;
    send(11'h0e5, 4, 0, 1);
    send(11'h1c0, 1, 0, 0);
    @(posedge clock_i) ce_i <= 1'b0;
    tick(300);
    check({7'h0, busy}, 8'h01);
    ce_i <= 1'b1;
    wait_done(d0);
    check(8'(rej_cnt), 8'h06);
    page_chk(11'h0e5);
    page_chk(11'h1c0);
    $display("test write while busy finished");
    stop_test();
  end
endmodule // tb_top
